// file: rtl/ccr_pkg.sv
// shared constants and carrier types for the compressor remote interface
package ccr_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam logic [12:0] CMD_HOLD_MS = 13'd300;
    localparam logic [12:0] RESTART_WIN_MS = 13'd300;
    localparam logic [12:0] INIT_MS = 13'd5000;
    localparam logic [12:0] SETTLE_MAX_MS = 13'd5000;
    localparam logic [12:0] SHORT_DROP_MS = 13'd2000;
    localparam logic [12:0] STOP_PULSE_MS = 13'd2000;
    localparam logic [12:0] POWERUP_PULSE_MS = 13'd500;
    localparam logic [3:0] GLITCH_CYCLES = 4'hf;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] SETTLE_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;
    localparam int CTRL_REMOTE_EN_BIT = 0;
    localparam int CTRL_ALARM_CLR_BIT = 1;
    localparam logic CTRL_REMOTE_EN_RESET = 1'b1;
    localparam logic [12:0] SETTLE_RESET = 13'd5000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------
    // synchronised input positions
    // ------------------------------------------------------------
    localparam int IN_START = 0;
    localparam int IN_STOP = 1;
    localparam int IN_LEVEL = 2;
    localparam int IN_HEAD_REQ = 3;
    localparam int IN_PUMP_FB = 6;
    localparam int IN_HEAD_FB = 7;
    localparam int IN_FAULT = 10;
    localparam int IN_RST_BTN = 11;
    localparam int IN_POWER = 12;
    localparam int IN_COUNT = 13;

    typedef enum logic [2:0] {
        ST_INIT = 3'b000,
        ST_IDLE = 3'b001,
        ST_SETTLE = 3'b010,
        ST_RUN = 3'b011,
        ST_DROP = 3'b100
    } ccr_state_type;

    typedef enum logic [1:0] {
        MODE_NONE = 2'b00,
        MODE_MOMENTARY = 2'b01,
        MODE_ALTERNATE = 2'b10
    } ccr_mode_type;

    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } ccr_axil_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ccr_axil_rsp_type;

endpackage : ccr_pkg

// file: rtl/ccr_remote_io.sv
// remote command and answer-back logic of the compressor controller
//
// Overview of operation
// - with pump running, each head request starts or stops its own head
// - with pump stopped, head replies stay low whatever the requests
// - compressor reply rises once the pump really runs after a run command
// - alarm low while ready or running, high on a detected fault
// - fault alarm holds until reset pressed, reset counts only once fault gone
// - alarm pulses about 2 s at compressor stop, 0.5 s at power-up
// - each head reply rises once that head really runs on its request
// - replies follow command changes within 0.3 s in normal operation
// - for 5 s after power-on commands are ignored and drives and replies stay off
// - run within 0.3 s of stop may wait up to 5 s for pressure
// - after a dropout under 2 s compressor reply may wait up to 5 s
// - momentary mode restarts a running pump after a dropout under 2 s
// - after a short dropout heads follow the current request levels
// - alternate mode restarts as soon as power returns, level still present
// - first compressor command after power-on fixes the mode until power off
// - momentary stop low over 0.3 s stops pump and heads, they stay stopped
// - alternate level high starts the pump, low stops pump and heads
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps

module ccr_remote_io #(
    parameter int TICK_CYCLES = ccr_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire ccr_pkg::ccr_axil_req_type axil_req,
    output ccr_pkg::ccr_axil_rsp_type axil_rsp,
    input wire logic comp_start_request,
    input wire logic comp_stop_request,
    input wire logic comp_level_request,
    input wire logic cooler_head1_request,
    input wire logic cooler_head2_request,
    input wire logic cooler_head3_request,
    input wire logic pump_running,
    input wire logic [2:0] cooler_head_running,
    input wire logic fault_detected,
    input wire logic alarm_reset_button,
    input wire logic input_power_good,
    output logic pump_drive,
    output logic [2:0] cooler_head_drive,
    output logic comp_reply,
    output logic alarm,
    output logic cooler_head1_reply,
    output logic cooler_head2_reply,
    output logic cooler_head3_reply
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (TICK_CYCLES < 2 || TICK_CYCLES > 16777215) begin : g_bad_tick
        $error("ccr_remote_io: TICK_CYCLES out of range");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam int NIN = ccr_pkg::IN_COUNT;

    typedef struct packed {
        logic [NIN-1:0] sync1;
        logic [NIN-1:0] sync2;
        logic [NIN-1:0] filt;
        logic [NIN-1:0][3:0] flt_cnt;
        logic [23:0] div_cnt;
        logic tick;
        ccr_pkg::ccr_state_type state;
        ccr_pkg::ccr_mode_type mode;
        logic [12:0] phase_ms;
        logic [12:0] start_ms;
        logic [12:0] stop_low_ms;
        logic [12:0] since_stop_ms;
        logic [12:0] pulse_ms;
        logic was_running;
        logic fault_latch;
        logic btn_prev;
        logic remote_en;
        logic alarm_clr;
        logic [12:0] settle_ms;
        logic pump_drive;
        logic [2:0] head_drive;
        logic comp_reply;
        logic [2:0] head_reply;
        logic alarm;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ccr_regs_type;

    ccr_regs_type r;
    ccr_regs_type next_r;

    logic [NIN-1:0] pins;
    logic wr_take;
    logic rd_take;

    assign pins = {input_power_good, alarm_reset_button, fault_detected,
        cooler_head_running, pump_running, cooler_head3_request,
        cooler_head2_request, cooler_head1_request, comp_level_request,
        comp_stop_request, comp_start_request};

    // both address and data are taken in one cycle, one write in flight
    assign wr_take = axil_req.awvalid && axil_req.wvalid && !r.bvalid;
    assign rd_take = axil_req.arvalid && !r.rvalid;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic run_req;
        logic stop_req;
        logic power;
        logic btn_press;
        logic [12:0] ms_inc;
        next_r = r;
        run_req = 1'b0;
        stop_req = 1'b0;
        power = r.filt[ccr_pkg::IN_POWER];
        btn_press = 1'b0;
        ms_inc = 13'd0;

        // two flops, then a stable-count filter on every remote input
        next_r.sync1 = pins;
        next_r.sync2 = r.sync1;
        for (int i = 0; i < NIN; i++) begin
            if (r.sync2[i] == r.filt[i]) begin
                next_r.flt_cnt[i] = 4'h0;
            end else if (r.flt_cnt[i] == ccr_pkg::GLITCH_CYCLES) begin
                next_r.filt[i] = r.sync2[i];
                next_r.flt_cnt[i] = 4'h0;
            end else begin
                next_r.flt_cnt[i] = r.flt_cnt[i] + 4'h1;
            end
        end

        // millisecond enable
        next_r.tick = 1'b0;
        if (r.div_cnt == 24'(TICK_CYCLES - 1)) begin
            next_r.div_cnt = 24'h000000;
            next_r.tick = 1'b1;
        end else begin
            next_r.div_cnt = r.div_cnt + 24'h000001;
        end
        if (r.tick) begin
            ms_inc = 13'd1;
        end

        // momentary qualification: start held, stop held low
        if (!r.filt[ccr_pkg::IN_START]) begin
            next_r.start_ms = 13'd0;
        end else if (r.start_ms < ccr_pkg::CMD_HOLD_MS) begin
            next_r.start_ms = r.start_ms + ms_inc;
        end
        if (r.filt[ccr_pkg::IN_STOP]) begin
            next_r.stop_low_ms = 13'd0;
        end else if (r.stop_low_ms < ccr_pkg::CMD_HOLD_MS) begin
            next_r.stop_low_ms = r.stop_low_ms + ms_inc;
        end
        if (r.since_stop_ms < ccr_pkg::RESTART_WIN_MS) begin
            next_r.since_stop_ms = r.since_stop_ms + ms_inc;
        end
        if (r.pulse_ms != 13'd0 && r.tick) begin
            next_r.pulse_ms = r.pulse_ms - 13'd1;
        end
        next_r.phase_ms = r.phase_ms + ms_inc;

        unique case (r.mode)
            ccr_pkg::MODE_MOMENTARY: begin
                run_req = r.start_ms == ccr_pkg::CMD_HOLD_MS
                    && r.filt[ccr_pkg::IN_STOP];
                stop_req = r.stop_low_ms == ccr_pkg::CMD_HOLD_MS;
            end
            ccr_pkg::MODE_ALTERNATE: begin
                run_req = r.filt[ccr_pkg::IN_LEVEL];
                stop_req = !r.filt[ccr_pkg::IN_LEVEL];
            end
            default: begin
                run_req = 1'b0;
                stop_req = 1'b0;
            end
        endcase

        // fault latch: set wins, release needs press with fault gone
        btn_press = (r.filt[ccr_pkg::IN_RST_BTN] && !r.btn_prev)
            || r.alarm_clr;
        next_r.btn_prev = r.filt[ccr_pkg::IN_RST_BTN];
        next_r.alarm_clr = 1'b0;
        if (r.filt[ccr_pkg::IN_FAULT]) begin
            next_r.fault_latch = 1'b1;
        end else if (btn_press) begin
            next_r.fault_latch = 1'b0;
        end

        unique case (r.state)
            ccr_pkg::ST_INIT: begin
                // commands ignored until the full init time has passed
                if (r.phase_ms >= ccr_pkg::INIT_MS) begin
                    next_r.state = ccr_pkg::ST_IDLE;
                    next_r.mode = ccr_pkg::MODE_NONE;
                    next_r.since_stop_ms = ccr_pkg::RESTART_WIN_MS;
                end
            end
            ccr_pkg::ST_IDLE: begin
                if (r.mode == ccr_pkg::MODE_NONE) begin
                    if (r.filt[ccr_pkg::IN_START]) begin
                        next_r.mode = ccr_pkg::MODE_MOMENTARY;
                    end else if (r.filt[ccr_pkg::IN_LEVEL]) begin
                        next_r.mode = ccr_pkg::MODE_ALTERNATE;
                    end
                end
                if (run_req && r.remote_en && !r.fault_latch) begin
                    next_r.phase_ms = 13'd0;
                    if (r.since_stop_ms < ccr_pkg::RESTART_WIN_MS) begin
                        next_r.state = ccr_pkg::ST_SETTLE;
                    end else begin
                        next_r.state = ccr_pkg::ST_RUN;
                    end
                end
            end
            ccr_pkg::ST_SETTLE: begin
                // pump waits for the helium pressure to settle
                if (stop_req || r.fault_latch) begin
                    next_r.state = ccr_pkg::ST_IDLE;
                end else if (r.phase_ms >= r.settle_ms) begin
                    next_r.state = ccr_pkg::ST_RUN;
                end
            end
            ccr_pkg::ST_RUN: begin
                if (stop_req || r.fault_latch || !r.remote_en) begin
                    next_r.state = ccr_pkg::ST_IDLE;
                    next_r.since_stop_ms = 13'd0;
                    next_r.pulse_ms = ccr_pkg::STOP_PULSE_MS;
                end
            end
            ccr_pkg::ST_DROP: begin
                if (power) begin
                    next_r.phase_ms = 13'd0;
                    if (r.mode == ccr_pkg::MODE_ALTERNATE
                            && r.filt[ccr_pkg::IN_LEVEL]) begin
                        next_r.state = ccr_pkg::ST_SETTLE;
                    end else if (r.mode == ccr_pkg::MODE_MOMENTARY
                            && r.was_running) begin
                        next_r.state = ccr_pkg::ST_SETTLE;
                    end else begin
                        next_r.state = ccr_pkg::ST_IDLE;
                    end
                end else if (r.phase_ms >= ccr_pkg::SHORT_DROP_MS) begin
                    // a long loss is a fresh power-up
                    next_r.state = ccr_pkg::ST_INIT;
                    next_r.mode = ccr_pkg::MODE_NONE;
                    next_r.phase_ms = 13'd0;
                    next_r.pulse_ms = ccr_pkg::POWERUP_PULSE_MS;
                end
            end
            default: begin
                next_r.state = ccr_pkg::ST_INIT;
            end
        endcase

        // a dropout overrides every state change made outside ST_INIT and ST_DROP
        if (!power && r.state != ccr_pkg::ST_INIT
                && r.state != ccr_pkg::ST_DROP) begin
            next_r.state = ccr_pkg::ST_DROP;
            next_r.phase_ms = 13'd0;
            next_r.was_running = r.state == ccr_pkg::ST_RUN
                || r.state == ccr_pkg::ST_SETTLE;
            if (r.state == ccr_pkg::ST_RUN) begin
                next_r.pulse_ms = ccr_pkg::STOP_PULSE_MS;
            end
        end

        // outputs, one cycle behind the decision
        next_r.pump_drive = r.state == ccr_pkg::ST_RUN;
        next_r.head_drive = r.state == ccr_pkg::ST_RUN
            ? r.filt[ccr_pkg::IN_HEAD_REQ +: 3] : 3'b000;
        next_r.comp_reply = r.pump_drive && r.filt[ccr_pkg::IN_PUMP_FB];
        next_r.head_reply = r.pump_drive ? r.head_drive
            & r.filt[ccr_pkg::IN_HEAD_FB +: 3] : 3'b000;
        next_r.alarm = r.fault_latch || r.pulse_ms != 13'd0;

        // register writes
        if (wr_take) begin
            next_r.bvalid = 1'b1;
            next_r.bresp = ccr_pkg::RESP_OKAY;
            unique case (axil_req.awaddr[7:0])
                ccr_pkg::CTRL_ADDR: begin
                    if (axil_req.wstrb[0]) begin
                        next_r.remote_en =
                            axil_req.wdata[ccr_pkg::CTRL_REMOTE_EN_BIT];
                        next_r.alarm_clr =
                            axil_req.wdata[ccr_pkg::CTRL_ALARM_CLR_BIT];
                    end
                end
                ccr_pkg::SETTLE_ADDR: begin
                    // never wait longer than the pressure worst case
                    if (axil_req.wstrb[1:0] == 2'b11) begin
                        next_r.settle_ms =
                            axil_req.wdata > 32'(ccr_pkg::SETTLE_MAX_MS)
                            ? ccr_pkg::SETTLE_MAX_MS : axil_req.wdata[12:0];
                    end
                end
                ccr_pkg::STATUS_ADDR: begin
                    next_r.bresp = ccr_pkg::RESP_OKAY;
                end
                default: begin
                    next_r.bresp = ccr_pkg::RESP_SLVERR;
                end
            endcase
            if (axil_req.awaddr[31:8] != 24'h000000) begin
                next_r.bresp = ccr_pkg::RESP_SLVERR;
            end
        end else if (r.bvalid && axil_req.bready) begin
            next_r.bvalid = 1'b0;
        end

        // register reads
        if (rd_take) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = ccr_pkg::RESP_OKAY;
            next_r.rdata = 32'h00000000;
            unique case (axil_req.araddr[7:0])
                ccr_pkg::CTRL_ADDR: begin
                    next_r.rdata[ccr_pkg::CTRL_REMOTE_EN_BIT] = r.remote_en;
                end
                ccr_pkg::SETTLE_ADDR: begin
                    next_r.rdata[12:0] = r.settle_ms;
                end
                ccr_pkg::STATUS_ADDR: begin
                    next_r.rdata[11:0] = {r.fault_latch, r.head_reply,
                        r.comp_reply, r.alarm, r.pump_drive, r.mode,
                        r.state};
                end
                default: begin
                    next_r.rresp = ccr_pkg::RESP_SLVERR;
                end
            endcase
            if (axil_req.araddr[31:8] != 24'h000000) begin
                next_r.rresp = ccr_pkg::RESP_SLVERR;
                next_r.rdata = 32'h00000000;
            end
        end else if (r.rvalid && axil_req.rready) begin
            next_r.rvalid = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
            r.state <= ccr_pkg::ST_INIT;
            r.mode <= ccr_pkg::MODE_NONE;
            r.pulse_ms <= ccr_pkg::POWERUP_PULSE_MS;
            r.remote_en <= ccr_pkg::CTRL_REMOTE_EN_RESET;
            r.settle_ms <= ccr_pkg::SETTLE_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign axil_rsp.awready = wr_take;
    assign axil_rsp.wready = wr_take;
    assign axil_rsp.bvalid = r.bvalid;
    assign axil_rsp.bresp = r.bresp;
    assign axil_rsp.arready = rd_take;
    assign axil_rsp.rvalid = r.rvalid;
    assign axil_rsp.rdata = r.rdata;
    assign axil_rsp.rresp = r.rresp;
    assign pump_drive = r.pump_drive;
    assign cooler_head_drive = r.head_drive;
    assign comp_reply = r.comp_reply;
    assign alarm = r.alarm;
    assign cooler_head1_reply = r.head_reply[0];
    assign cooler_head2_reply = r.head_reply[1];
    assign cooler_head3_reply = r.head_reply[2];

endmodule : ccr_remote_io

// file: tb/ccr_remote_io_assertions.sv
// assertion checker for the compressor remote interface
`timescale 1ns/1ps
module ccr_remote_io_checker #(
    parameter int TICK_CYCLES = 10
) (
    input wire logic clk,
    input wire logic reset,
    input wire ccr_pkg::ccr_axil_req_type axil_req,
    input wire ccr_pkg::ccr_axil_rsp_type axil_rsp,
    input wire logic fault_detected,
    input wire logic alarm_reset_button,
    input wire logic input_power_good,
    input wire logic pump_drive,
    input wire logic [2:0] cooler_head_drive,
    input wire logic comp_reply,
    input wire logic alarm,
    input wire logic cooler_head1_reply
);
    // ----
    // helper: consecutive fault cycles, past the input filter
    // ----
    logic [5:0] fault_cnt;
    always_ff @(posedge clk) begin
        if (reset || !fault_detected) begin
            fault_cnt <= 6'h00;
        end else if (fault_cnt != 6'h3f) begin
            fault_cnt <= fault_cnt + 6'h01;
        end
    end
    // ----
    // properties
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_wr_take;
        axil_req.awvalid && axil_req.wvalid && !axil_rsp.bvalid;
    endsequence
    sequence s_rd_take;
        axil_req.arvalid && !axil_rsp.rvalid;
    endsequence
    sequence s_press_in_fault;
        $rose(alarm_reset_button) && fault_detected && alarm;
    endsequence
    a_reset_quiet: assert property (
        $fell(reset) |-> !pump_drive && !comp_reply && cooler_head_drive == 3'h0)
        else $error("drives active at reset release");
    a_powerup_pulse: assert property (
        $fell(reset) |-> ##[0:2] alarm) else $error("no power-up alarm pulse");
    a_comp_reply_cause: assert property (
        $rose(comp_reply) |-> $past(pump_drive) && pump_drive)
        else $error("compressor reply without pump drive");
    a_head_reply_cause: assert property (
        $rose(cooler_head1_reply) |-> $past(cooler_head_drive[0]))
        else $error("head reply without head drive");
    a_head_needs_pump: assert property (
        cooler_head1_reply |-> $past(pump_drive, 2))
        else $error("head reply while pump stopped");
    a_stop_pulse: assert property (
        $fell(pump_drive) && input_power_good |-> ##[0:3] alarm)
        else $error("no alarm pulse at stop");
    a_fault_alarm: assert property (
        fault_cnt >= 6'd24 |-> alarm) else $error("fault without alarm");
    a_reset_blocked: assert property (
        s_press_in_fault |=> alarm[*8]) else $error("alarm cleared in fault");
    a_write_answer: assert property (
        s_wr_take |=> axil_rsp.bvalid) else $error("write response late");
    a_read_answer: assert property (
        s_rd_take |=> axil_rsp.rvalid) else $error("read response late");
endmodule : ccr_remote_io_checker

bind ccr_remote_io ccr_remote_io_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk(clk), .reset(reset), .axil_req(axil_req), .axil_rsp(axil_rsp),
    .fault_detected(fault_detected), .alarm_reset_button(alarm_reset_button),
    .input_power_good(input_power_good), .pump_drive(pump_drive),
    .cooler_head_drive(cooler_head_drive), .comp_reply(comp_reply),
    .alarm(alarm), .cooler_head1_reply(cooler_head1_reply));

// file: tb/ccr_host_model.sv
// host controller model: run level and answer-back timeout
`timescale 1ns/1ps
module ccr_host_model #(
    parameter int TICK_CYCLES = 10
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic want_run,
    input wire logic comp_reply,
    output logic comp_level_request = 1'b0,
    output logic reply_missing = 1'b0
);
    // timeout must cover init or settle delay plus margin
    localparam int TIMEOUT = 8000 * TICK_CYCLES;
    int wait_cnt = 0;
    always @(posedge clk) begin
        // level only changes on bench request, held for at least 260 cycles
        comp_level_request <= want_run;
        if (reset || comp_level_request == comp_reply) begin
            wait_cnt <= 0;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
        if (!reset && wait_cnt > TIMEOUT) begin
            reply_missing <= 1'b1;
        end
    end
endmodule : ccr_host_model

// file: tb/cryo_compressor_remote_io_test.sv
// self-checking bench for the compressor remote interface
`timescale 1ns/1ps
module cryo_compressor_remote_io_test;
    localparam int TICK = 10;
    logic clk = 1'b0;
    logic reset = 1'b1;
    ccr_pkg::ccr_axil_req_type req = '0;
    ccr_pkg::ccr_axil_rsp_type rsp;
    logic want_run = 1'b0;
    logic [2:0] head_req = 3'h0;
    logic fault = 1'b0;
    logic btn = 1'b0;
    logic pwr = 1'b1;
    logic pump_run = 1'b0;
    logic [2:0] head_run = 3'h0;
    logic level, missing, pump_drive, comp_reply, alarm;
    logic [2:0] head_drive, reply;
    logic [31:0] rd_data;
    int failures = 0;
    int compares = 0;
    // ----
    // clock, plant feedback one cycle behind drive
    // ----
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        pump_run <= pump_drive;
        head_run <= head_drive;
    end
    ccr_remote_io #(.TICK_CYCLES(TICK)) u_dut (
        .clk(clk), .reset(reset), .axil_req(req), .axil_rsp(rsp),
        .comp_start_request(1'b0), .comp_stop_request(1'b1),
        .comp_level_request(level), .cooler_head1_request(head_req[0]),
        .cooler_head2_request(head_req[1]), .cooler_head3_request(head_req[2]),
        .pump_running(pump_run), .cooler_head_running(head_run),
        .fault_detected(fault), .alarm_reset_button(btn),
        .input_power_good(pwr), .pump_drive(pump_drive),
        .cooler_head_drive(head_drive), .comp_reply(comp_reply), .alarm(alarm),
        .cooler_head1_reply(reply[0]), .cooler_head2_reply(reply[1]),
        .cooler_head3_reply(reply[2]));
    ccr_host_model #(.TICK_CYCLES(TICK)) u_host (
        .clk(clk), .reset(reset), .want_run(want_run), .comp_reply(comp_reply),
        .comp_level_request(level), .reply_missing(missing));
    // ----
    // tasks
    // ----
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        @(posedge clk);
        req.awaddr <= {24'h000000, a};
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do @(negedge clk); while (!(rsp.awready && rsp.wready));
        @(posedge clk);
        req.awvalid <= 1'b0;
        req.wvalid <= 1'b0;
        do @(negedge clk); while (!rsp.bvalid);
        chk("bresp", er, rsp.bresp);
        @(posedge clk);
        req.bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        @(posedge clk);
        req.araddr <= {24'h000000, a};
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do @(negedge clk); while (!rsp.arready);
        @(posedge clk);
        req.arvalid <= 1'b0;
        do @(negedge clk); while (!rsp.rvalid);
        rd_data = rsp.rdata;
        chk("rresp", er, rsp.rresp);
        @(posedge clk);
        req.rready <= 1'b0;
    endtask : rd
    task automatic print_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    // ----
    // watchdog: whole run is about 80k cycles
    // ----
    initial begin
        #1000000;
        failures++;
        $display("Error watchdog expected done seen timeout");
        print_verdict();
    end
    // ----
    // tests
    // ----
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        chk("alarm", 1, alarm);
        rd(ccr_pkg::STATUS_ADDR, ccr_pkg::RESP_OKAY);
        chk("status", 32'h00000040, rd_data);
        rd(ccr_pkg::CTRL_ADDR, ccr_pkg::RESP_OKAY);
        chk("ctrl", 32'h00000001, rd_data);
        wr(ccr_pkg::SETTLE_ADDR, 32'h00012000, ccr_pkg::RESP_OKAY);
        rd(ccr_pkg::SETTLE_ADDR, ccr_pkg::RESP_OKAY);
        chk("settle", 32'h00001388, rd_data);
        // short settle keeps the dropout case cheap
        wr(ccr_pkg::SETTLE_ADDR, 32'h0000000a, ccr_pkg::RESP_OKAY);
        wr(ccr_pkg::STATUS_ADDR, 32'h00000000, ccr_pkg::RESP_OKAY);
        wr(8'h0c, 32'h00000001, ccr_pkg::RESP_SLVERR);
        rd(8'h0c, ccr_pkg::RESP_SLVERR);
        chk("unmapped", 32'h00000000, rd_data);
        want_run <= 1'b1;
        head_req <= 3'h5;
        repeat (40000) @(posedge clk);
        chk("pump_drive", 0, pump_drive);
        chk("head_reply", 0, reply);
        repeat (13500) @(posedge clk);
        chk("comp_reply", 1, comp_reply);
        chk("head_reply", 5, reply);
        rd(ccr_pkg::STATUS_ADDR, ccr_pkg::RESP_OKAY);
        chk("mode", 2, rd_data[4:3]);
        head_req <= 3'h6;
        repeat (3050) @(posedge clk);
        chk("head_reply", 6, reply);
        pwr <= 1'b0;
        repeat (500) @(posedge clk);
        chk("pump_drive", 0, pump_drive);
        repeat (500) @(posedge clk);
        pwr <= 1'b1;
        repeat (1000) @(posedge clk);
        chk("comp_reply", 1, comp_reply);
        chk("head_reply", 6, reply);
        chk("head_drive", 6, head_drive);
        want_run <= 1'b0;
        repeat (300) @(posedge clk);
        chk("pump_drive", 0, pump_drive);
        want_run <= 1'b1;
        repeat (60) @(posedge clk);
        chk("pump_drive", 0, pump_drive);
        repeat (200) @(posedge clk);
        chk("pump_drive", 1, pump_drive);
        want_run <= 1'b0;
        repeat (3050) @(posedge clk);
        chk("pump_drive", 0, pump_drive);
        chk("head_reply", 0, reply);
        chk("alarm", 1, alarm);
        repeat (12000) @(posedge clk);
        chk("alarm", 1, alarm);
        repeat (6000) @(posedge clk);
        chk("alarm", 0, alarm);
        fault <= 1'b1;
        repeat (50) @(posedge clk);
        chk("alarm", 1, alarm);
        btn <= 1'b1;
        repeat (50) @(posedge clk);
        btn <= 1'b0;
        repeat (50) @(posedge clk);
        chk("alarm", 1, alarm);
        fault <= 1'b0;
        repeat (50) @(posedge clk);
        chk("alarm", 1, alarm);
        btn <= 1'b1;
        repeat (50) @(posedge clk);
        btn <= 1'b0;
        repeat (50) @(posedge clk);
        chk("alarm", 0, alarm);
        chk("reply_missing", 0, missing);
        print_verdict();
    end
endmodule : cryo_compressor_remote_io_test
